// file: pcs_defs.svh
// Purpose: Offsets, field positions, reset values and timing of the
//          power-channel sequencer.
// Assumes: Byte addresses on a 32-bit register bus.
// Notes:   Definitions only.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PCS_OFS_CTRL     4'h0
`define PCS_OFS_VOLT     4'h4
`define PCS_OFS_BLIT     4'h8
`define PCS_OFS_STAT     4'hc
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCS_CTRL_PWM     0
`define PCS_CTRL_CH1     3
`define PCS_VOLT_B5      0
`define PCS_VOLT_L6      4
`define PCS_VOLT_L8      8
`define PCS_BLIT_DIM     0
`define PCS_BLIT_BOOST   8
`define PCS_BLIT_OVP     9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PCS_RST_B5       4'h0
`define PCS_RST_L6       4'h4
`define PCS_RST_L8       4'hc
`define PCS_RST_DIM      5'h1f
`define PCS_SEQ_OPEN     3'h5
// ----------------------------------------
// Timing
// ----------------------------------------
`define PCS_CLK_HZ       50000000
`define PCS_STEP_MS      10
`define PCS_SS_MS        4
`define PCS_PWM_FAST_HZ  2000000
`define PCS_PWM_SLOW_HZ  1000000
`define PCS_FB_SETTLE    20'h00003
`define PCS_STRAP_WAIT   2'h3
`define PCS_TW           20
`endif

// file: pcs_div.sv
// Purpose: Free-running divider giving a one-cycle enable pulse.
// Assumes: DIV counts system clocks per pulse.
// Notes:   Pulse comes from a flip-flop.
`timescale 1ns/1ps
module pcs_div #(
  parameter int DIV = 25
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Enable pulse
  output logic      tick
);
  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } pcs_div_st_t;

  pcs_div_st_t q;
  pcs_div_st_t d;

  generate
    if (DIV < 2) begin : g_bad
      $error("pcs_div: divide ratio must be at least two");
    end
  endgenerate

  // Wrap at DIV-1 and pulse on the wrap
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == CW'(DIV - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule : pcs_div

// file: pcs_pkg.sv
// Purpose: Types shared by the power-channel sequencer.
// Assumes: pcs_defs.svh supplies the widths.
// Notes:   State codes are Gray along off, up, on, down.
`include "pcs_defs.svh"
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_OFF  = 2'b00,
    PCS_UP   = 2'b01,
    PCS_ON   = 2'b11,
    PCS_DOWN = 2'b10
  } pcs_state_t;

  typedef struct packed {
    logic [3:0]            b5_code;
    logic [3:0]            l6_code;
    logic [3:0]            l8_code;
    logic [4:0]            dim;
    logic                  bl_boost;
    logic                  bl_ovp;
    logic                  b5_pwm;
    logic                  ch1_reg;
    logic                  ext_fb;
    logic                  waitreq;
    logic [31:0]           rdata;
    pcs_state_t            st;
    logic [2:0]            idx;
    logic [`PCS_TW-1:0]    timer;
    logic [`PCS_TW-1:0]    ss_cnt;
    logic [4:0]            ch_en;
    logic [4:0]            ss;
    logic [4:0]            dis;
    logic [2:0]            seq;
    logic [1:0]            strap_cnt;
    logic                  strap_done;
    logic                  clk_fast;
    logic                  clk_slow;
  } pcs_regs_t;
endpackage : pcs_pkg

// file: pcs_rail_model.sv
// Purpose: Converter outputs as the sequencer sees them.
// Assumes: An output reads below threshold lim+1 clocks after turn-off.
// Notes:   Behavioural; a large lim models a slow discharge.
`timescale 1ns/1ps
module pcs_rail_model (
  // Clock
  input  wire logic       clock,
  // Channel enables and decay time
  input  wire logic [4:0] chan_enable,
  input  wire logic [7:0] lim,
  // Feedback-low flags
  output logic      [4:0] fb_below_thresh
);
  logic [7:0] cnt [5] = '{default: 8'h00};
  // -----------------------------
  // Output decay
  // -----------------------------
  // Flag only rises once the output had time to bleed down
  always_ff @(posedge clock) begin
    for (int i = 0; i < 5; i++) begin
      if (chan_enable[i])
        cnt[i] <= 8'h00;
      else if (cnt[i] < lim)
        cnt[i] <= cnt[i] + 8'h01;
      fb_below_thresh[i] <= !chan_enable[i] && cnt[i] >= lim;
    end
  end
endmodule : pcs_rail_model

// file: pcs_sync.sv
// Purpose: Two-stage synchroniser for pin-level inputs.
// Assumes: Inputs are slow levels from outside the clock domain.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module pcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pcs_sync_st_t;

  pcs_sync_st_t q;
  pcs_sync_st_t d;

  generate
    if (W < 1) begin : g_bad
      $error("pcs_sync: width must be at least one");
    end
  endgenerate

  // First stage feeds only the second
  always_comb begin
    d.meta = din;
    d.sync = q.meta;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.sync;
endmodule : pcs_sync

// file: pmu_channel_sequencer.sv
// Purpose: Channel settings and power on/off ordering of a PMU.
// Assumes: Strap and feedback comparators are digitised off-chip.
// Notes:   Registers over Avalon-MM; one clock at 50 MHz.
//
// How it works
// - Buck5 4-bit voltage code, resets to external.
// - Code zero selects external feedback network.
// - Buck5 bit picks PFM or sync PWM.
// - LDO6 4-bit code, reset selects 1.8V.
// - LDO8 4-bit code, reset selects 2.5V.
// - Backlight bit picks current source or boost.
// - Backlight 5-bit dimming field, value over 31.
// - Boost mode bit limits output, 15V/21V.
// - Fast channels 2MHz, slow channels 1MHz.
// - Strap decodes to sequence 0..5, open is 5.
// - Fixed channel orders for sequences 1 to 5.
// - Sequence 0 orders 2,3,4; channel1 by register.
// - Group enable rise starts; 10ms between channels.
// - Each channel gets a 4ms soft start; channel1 in sequence 0 gets none.
// - Off in reverse, waiting each feedback below threshold.
// - Off complete when last feedback falls low.
// - Falling enable ignored during power-on sequence.
// - Rising enable ignored during power-off sequence.
`timescale 1ns/1ps
module pmu_channel_sequencer
  import pcs_pkg::*;
#(
  parameter int STEP_CYCLES = `PCS_STEP_MS * (`PCS_CLK_HZ / 1000),
  parameter int SS_CYCLES   = `PCS_SS_MS * (`PCS_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins: group enable, strap, feedback-low flags
  input  wire logic        main_group_enable,
  input  wire logic [2:0]  sequence_strap,
  input  wire logic [4:0]  fb_below_thresh,
  // Channel controls, bit 0 is channel 1
  output logic      [4:0]  chan_enable,
  output logic      [4:0]  chan_soft_start,
  output logic      [4:0]  chan_discharge,
  // Converter clock enables
  output logic             pwm_tick_fast,
  output logic             pwm_tick_slow,
  // Analog settings
  output logic      [3:0]  buck5_voltage_code,
  output logic             buck5_ext_feedback,
  output logic             buck5_pwm_mode,
  output logic      [3:0]  ldo6_voltage_code,
  output logic      [3:0]  ldo8_voltage_code,
  output logic      [4:0]  backlight_dim_level,
  output logic             backlight_boost_mode,
  output logic             backlight_ovp_high
);
  import pcs_pkg::*;

  localparam int DIV_FAST = `PCS_CLK_HZ / `PCS_PWM_FAST_HZ;
  localparam int DIV_SLOW = `PCS_CLK_HZ / `PCS_PWM_SLOW_HZ;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (STEP_CYCLES >= (1 << `PCS_TW) || STEP_CYCLES < 2 ||
        SS_CYCLES < 1 || SS_CYCLES >= STEP_CYCLES) begin : g_bad
      $error("pmu_channel_sequencer: timing counts out of range");
    end
  endgenerate

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Channel (0 = channel 1) at a position of a sequence order
  function automatic logic [2:0] pcs_order(input logic [2:0] seq,
                                           input logic [2:0] pos);
    logic [14:0] tbl;
    tbl = 15'h0000;
    unique case (seq)
      3'h0: tbl = {3'h0, 3'h0, 3'h3, 3'h2, 3'h1};
      3'h1: tbl = {3'h0, 3'h3, 3'h1, 3'h2, 3'h0};
      3'h2: tbl = {3'h0, 3'h1, 3'h3, 3'h2, 3'h0};
      3'h3: tbl = {3'h0, 3'h2, 3'h3, 3'h1, 3'h0};
      3'h4: tbl = {3'h4, 3'h1, 3'h2, 3'h3, 3'h0};
      default: tbl = {3'h0, 3'h2, 3'h1, 3'h3, 3'h0};
    endcase
    return tbl[pos*3 +: 3];
  endfunction : pcs_order

  // Last position of a sequence order
  function automatic logic [2:0] pcs_last(input logic [2:0] seq);
    logic [2:0] n;
    n = 3'h3;
    if (seq == 3'h0) begin
      n = 3'h2;
    end else if (seq == 3'h4) begin
      n = 3'h4;
    end
    return n;
  endfunction : pcs_last

  // ----------------------------------------
  // Pin synchronisers and dividers
  // ----------------------------------------
  logic       grp_s;
  logic [2:0] strap_s;
  logic [4:0] fb_s;
  logic       tick_fast;
  logic       tick_slow;

  pcs_sync #(.W(9)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     ({main_group_enable, sequence_strap, fb_below_thresh}),
    .dout    ({grp_s, strap_s, fb_s})
  );

  pcs_div #(.DIV(DIV_FAST)) u_div_fast (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick_fast)
  );

  pcs_div #(.DIV(DIV_SLOW)) u_div_slow (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick_slow)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  pcs_regs_t  q;
  pcs_regs_t  d;
  logic [2:0] cur;
  logic [2:0] last;
  logic [31:0] wmask;

  assign cur   = pcs_order(q.seq, q.idx);
  assign last  = pcs_last(q.seq);
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Next-state logic: bus slave, strap capture, sequencer
  always_comb begin
    logic [31:0] wv;
    logic [2:0]  nch;
    wv  = 32'h0;
    nch = 3'h0;
    d   = q;
    d.clk_fast = tick_fast;
    d.clk_slow = tick_slow;

    // Bus: one wait cycle, then answer; write lands on the answer edge
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      if (avs_read) begin
        unique case (avs_address)
          `PCS_OFS_CTRL: d.rdata = {28'h0, q.ch1_reg, 2'h0, q.b5_pwm};
          `PCS_OFS_VOLT: d.rdata = {20'h0, q.l8_code, q.l6_code,
                                    q.b5_code};
          `PCS_OFS_BLIT: d.rdata = {22'h0, q.bl_ovp, q.bl_boost, 3'h0,
                                    q.dim};
          `PCS_OFS_STAT: d.rdata = {3'h0, q.dis, 3'h0, q.ss,
                                    3'h0, q.ch_en, q.strap_done,
                                    q.seq, 2'h0, q.st};
          default:       d.rdata = 32'h0;
        endcase
      end
    end
    if (avs_write && !q.waitreq) begin
      unique case (avs_address)
        `PCS_OFS_CTRL: begin
          wv = ({28'h0, q.ch1_reg, 2'h0, q.b5_pwm} & ~wmask) |
               (avs_writedata & wmask);
          d.b5_pwm  = wv[`PCS_CTRL_PWM];
          d.ch1_reg = wv[`PCS_CTRL_CH1];
        end
        `PCS_OFS_VOLT: begin
          wv = ({20'h0, q.l8_code, q.l6_code, q.b5_code} & ~wmask) |
               (avs_writedata & wmask);
          d.b5_code = wv[`PCS_VOLT_B5 +: 4];
          d.l6_code = wv[`PCS_VOLT_L6 +: 4];
          d.l8_code = wv[`PCS_VOLT_L8 +: 4];
        end
        `PCS_OFS_BLIT: begin
          wv = ({22'h0, q.bl_ovp, q.bl_boost, 3'h0, q.dim} & ~wmask) |
               (avs_writedata & wmask);
          d.dim      = wv[`PCS_BLIT_DIM +: 5];
          d.bl_boost = wv[`PCS_BLIT_BOOST];
          d.bl_ovp   = wv[`PCS_BLIT_OVP];
        end
        default: begin
          wv = 32'h0;
        end
      endcase
    end
    d.ext_fb = (d.b5_code == 4'h0);

    // Strap settles through the synchroniser before it is taken once
    if (!q.strap_done) begin
      if (q.strap_cnt == `PCS_STRAP_WAIT) begin
        d.seq        = (strap_s > `PCS_SEQ_OPEN) ? `PCS_SEQ_OPEN
                                                  : strap_s;
        d.strap_done = 1'b1;
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end

    if (q.timer != '0) begin
      d.timer = q.timer - 1'b1;
    end
    if (q.ss_cnt != '0) begin
      d.ss_cnt = q.ss_cnt - 1'b1;
      if (q.ss_cnt == `PCS_TW'(1)) begin
        d.ss = 5'h00;
      end
    end

    unique case (q.st)
      PCS_OFF: begin
        if (q.strap_done && grp_s) begin
          nch        = pcs_order(q.seq, 3'h0);
          d.st       = PCS_UP;
          d.idx      = 3'h0;
          d.ch_en[nch] = 1'b1;
          d.dis      = 5'h00;
          d.ss       = 5'h01 << nch;
          d.ss_cnt   = `PCS_TW'(SS_CYCLES);
          d.timer    = `PCS_TW'(STEP_CYCLES - 1);
        end
      end
      PCS_UP: begin
        if (q.idx == last) begin
          if (q.ss_cnt == '0) begin
            d.st = PCS_ON;
          end
        end else if (q.timer == '0) begin
          nch          = pcs_order(q.seq, q.idx + 3'h1);
          d.idx        = q.idx + 3'h1;
          d.ch_en[nch] = 1'b1;
          d.ss         = 5'h01 << nch;
          d.ss_cnt     = `PCS_TW'(SS_CYCLES);
          d.timer      = `PCS_TW'(STEP_CYCLES - 1);
        end
      end
      PCS_ON: begin
        if (!grp_s) begin
          d.st         = PCS_DOWN;
          d.idx        = last;
          d.ch_en[last == 3'h4 ? 3'h4 : pcs_order(q.seq, last)] = 1'b0;
          d.dis[pcs_order(q.seq, last)] = 1'b1;
          d.ss         = 5'h00;
          d.ss_cnt     = '0;
          d.timer      = `PCS_FB_SETTLE;
        end
      end
      PCS_DOWN: begin
        if (q.timer == '0 && fb_s[cur]) begin
          if (q.idx == 3'h0) begin
            d.st  = PCS_OFF;
            d.dis = 5'h00;
          end else begin
            nch          = pcs_order(q.seq, q.idx - 3'h1);
            d.idx        = q.idx - 3'h1;
            d.ch_en[nch] = 1'b0;
            d.dis[nch]   = 1'b1;
            d.timer      = `PCS_FB_SETTLE;
          end
        end
      end
    endcase

    if (q.strap_done && q.seq == 3'h0) begin
      d.ch_en[0] = q.ch1_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q            <= '0;
      q.b5_code    <= `PCS_RST_B5;
      q.l6_code    <= `PCS_RST_L6;
      q.l8_code    <= `PCS_RST_L8;
      q.dim        <= `PCS_RST_DIM;
      q.ext_fb     <= 1'b1;
      q.waitreq    <= 1'b1;
      q.st         <= PCS_OFF;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs straight from state
  // ----------------------------------------
  assign avs_readdata         = q.rdata;
  assign avs_waitrequest      = q.waitreq;
  assign chan_enable          = q.ch_en;
  assign chan_soft_start      = q.ss;
  assign chan_discharge       = q.dis;
  assign pwm_tick_fast        = q.clk_fast;
  assign pwm_tick_slow        = q.clk_slow;
  assign buck5_voltage_code   = q.b5_code;
  assign buck5_ext_feedback   = q.ext_fb;
  assign buck5_pwm_mode       = q.b5_pwm;
  assign ldo6_voltage_code    = q.l6_code;
  assign ldo8_voltage_code    = q.l8_code;
  assign backlight_dim_level  = q.dim;
  assign backlight_boost_mode = q.bl_boost;
  assign backlight_ovp_high   = q.bl_ovp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Cycles since the last enable rise, and soft-start length
  logic [4:0]         en_prev;
  logic [`PCS_TW-1:0] gap;
  logic [`PCS_TW-1:0] ss_run;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_prev <= 5'h00;
      gap     <= '0;
      ss_run  <= '0;
    end else begin
      en_prev <= q.ch_en;
      gap     <= (|(q.ch_en & ~en_prev)) ? `PCS_TW'(1) : gap + 1'b1;
      ss_run  <= (q.ss != 5'h00) ? ss_run + 1'b1 : '0;
    end
  end

  sequence s_step_rise;
    q.st == PCS_UP && (|(q.ch_en & ~en_prev)) && q.idx != 3'h0;
  endsequence

  sequence s_down_done;
    $past(q.st) == PCS_DOWN && q.st == PCS_OFF;
  endsequence

  property p_reset_off;
    @(posedge clock) $fell(sys_rst) |-> q.ch_en == 5'h00 && q.ss == 5'h00;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("channel enabled right after reset");

  property p_ext_fb;
    @(posedge clock) disable iff (sys_rst)
      buck5_ext_feedback == (buck5_voltage_code == 4'h0);
  endproperty
  a_ext_fb: assert property (p_ext_fb)
    else $error("external feedback flag disagrees with code");

  property p_step;
    @(posedge clock) disable iff (sys_rst)
      s_step_rise |-> $past(gap) == `PCS_TW'(STEP_CYCLES - 1);
  endproperty
  a_step: assert property (p_step)
    else $error("channel step spacing wrong");

  property p_soft;
    @(posedge clock) disable iff (sys_rst)
      $fell(|q.ss) && $past(q.st) != PCS_ON |-> ss_run ==
        `PCS_TW'(SS_CYCLES);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft-start length wrong");

  property p_up_holds;
    @(posedge clock) disable iff (sys_rst)
      q.st == PCS_UP |=> q.st != PCS_DOWN;
  endproperty
  a_up_holds: assert property (p_up_holds)
    else $error("power-on sequence interrupted");

  property p_down_holds;
    @(posedge clock) disable iff (sys_rst)
      q.st == PCS_DOWN |=> q.st != PCS_UP;
  endproperty
  a_down_holds: assert property (p_down_holds)
    else $error("power-off sequence interrupted");

  property p_wait_fb;
    @(posedge clock) disable iff (sys_rst)
      q.st == PCS_DOWN && !fb_s[cur] |=> q.ch_en[4:1] == $past(q.ch_en[4:1]);
  endproperty
  a_wait_fb: assert property (p_wait_fb)
    else $error("channel turned off before feedback low");

  property p_off_done;
    @(posedge clock) disable iff (sys_rst)
      s_down_done |-> $past(fb_s[pcs_order(q.seq, 3'h0)]);
  endproperty
  a_off_done: assert property (p_off_done)
    else $error("off sequence ended early");

  property p_strap;
    @(posedge clock) disable iff (sys_rst)
      q.strap_done |-> q.seq <= `PCS_SEQ_OPEN ##1 $stable(q.seq);
  endproperty
  a_strap: assert property (p_strap)
    else $error("sequence number out of range or changed");

  property p_seq0_ch1;
    @(posedge clock) disable iff (sys_rst)
      q.strap_done && q.seq == 3'h0 |=> q.ch_en[0] == $past(q.ch1_reg);
  endproperty
  a_seq0_ch1: assert property (p_seq0_ch1)
    else $error("channel 1 does not follow its register bit");

  property p_fast;
    @(posedge clock) disable iff (sys_rst)
      pwm_tick_fast |=> !pwm_tick_fast ##24 pwm_tick_fast;
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast converter tick period wrong");
endmodule : pmu_channel_sequencer

// file: pmu_channel_sequencer_tb.sv
// Purpose: Self-checking bench of the power-channel sequencer.
// Assumes: Short step and soft-start counts keep the run brief.
// Notes:   Strap is read once, so each order gets its own reset.
`timescale 1ns/1ps
module pmu_channel_sequencer_tb;
  localparam int STEP = 40;
  localparam int SS   = 16;
  logic        clock, sys_rst, avs_read, avs_write, grp_en, tf, ts;
  logic [3:0]  avs_address, avs_byteenable, b5, l6, l8;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        avs_waitrequest, b5_ext, b5_pwm, bl_boost, bl_ovp;
  logic [2:0]  strap;
  logic [4:0]  fb, en, ssb, dis, dim, en_p, dis_p;
  logic [7:0]  lim;
  int          fail_count, total_checks, cyc, ss_cyc, dis_t;
  int          on_q[$], on_t[$], off_q[$], off_t[$];

  pmu_channel_sequencer #(.STEP_CYCLES(STEP), .SS_CYCLES(SS)) dut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .main_group_enable(grp_en), .sequence_strap(strap),
    .fb_below_thresh(fb), .chan_enable(en), .chan_soft_start(ssb),
    .chan_discharge(dis), .pwm_tick_fast(tf), .pwm_tick_slow(ts),
    .buck5_voltage_code(b5), .buck5_ext_feedback(b5_ext),
    .buck5_pwm_mode(b5_pwm), .ldo6_voltage_code(l6),
    .ldo8_voltage_code(l8), .backlight_dim_level(dim),
    .backlight_boost_mode(bl_boost), .backlight_ovp_high(bl_ovp));
  pcs_rail_model rails (.clock(clock), .chan_enable(en), .lim(lim),
    .fb_below_thresh(fb));

  // ------------------------------
  // Clock and switching monitor
  // ------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Edges of each enable are logged with their cycle
  always @(posedge clock) begin
    cyc++;
    for (int i = 0; i < 5; i++) begin
      if (en[i] === 1'b1 && en_p[i] === 1'b0) begin
        on_q.push_back(i + 1);
        on_t.push_back(cyc);
      end
      if (en[i] === 1'b0 && en_p[i] === 1'b1) begin
        off_q.push_back(i + 1);
        off_t.push_back(cyc);
      end
    end
    if (|ssb)
      ss_cyc++;
    if (dis_p != 5'h00 && dis === 5'h00)
      dis_t = cyc;
    en_p = en;
    dis_p = dis;
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic tmo(input int n, input int lim_n);
    if (n >= lim_n) begin
      fail_count++;
      conclude();
    end
  endtask : tmo

  // Holds the request until waitrequest is seen low, then idles a cycle
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
    tmo(n, 50);
  endtask : bus

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset_vals;
    bus(4'h4, 1'b0, 0);
    chk("volt", rd, 32'h00000c40);
    bus(4'h8, 1'b0, 0);
    chk("blit", rd, 32'h0000001f);
    chk("ext_fb", b5_ext, 1);
    chk("enables", en, 0);
    bus(4'h2, 1'b1, 32'hffffffff);
    bus(4'h2, 1'b0, 0);
    chk("unmapped", rd, 0);
  endtask : t_reset_vals

  task automatic t_regs;
    bus(4'h4, 1'b1, 32'h00000f35);
    chk("b5", b5, 5);
    chk("ext_fb", b5_ext, 0);
    chk("l6", l6, 3);
    chk("l8", l8, 15);
    bus(4'h8, 1'b1, 32'h0000031e);
    chk("dim", dim, 5'h1e);
    chk("boost", bl_boost, 1);
    chk("ovp", bl_ovp, 1);
    bus(4'h0, 1'b1, 32'h00000001);
    chk("pwm", b5_pwm, 1);
    avs_byteenable <= 4'h1;
    bus(4'h4, 1'b1, 0);
    avs_byteenable <= 4'hf;
    chk("b5 ext", {b5_ext, b5, l8}, 9'h10f);
  endtask : t_regs

  task automatic t_ticks;
    int f;
    int s;
    f = 0;
    s = 0;
    repeat (250) begin
      @(posedge clock);
      f += tf;
      s += ts;
    end
    chk("fast ticks", f, 10);
    chk("slow ticks", s, 5);
  endtask : t_ticks

  // Full on and off pass for one strap; early drops enable during on,
  // late raises it again during off
  task automatic run_seq(input logic [2:0] sv, input int n,
    input logic [19:0] ord, input bit early, input bit late,
    input logic [7:0] lm);
    int k;
    strap <= sv;
    grp_en <= 1'b0;
    lim <= lm;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clock);
    bus(4'hc, 1'b0, 0);
    chk("seq", rd[6:4], (sv > 3'd5) ? 3'd5 : sv);
    on_q.delete();
    on_t.delete();
    off_q.delete();
    off_t.delete();
    ss_cyc = 0;
    dis_t = 0;
    grp_en <= 1'b1;
    if (early) begin
      repeat (STEP + 5) @(posedge clock);
      grp_en <= 1'b0;
    end
    for (k = 0; k < 8 * STEP && on_q.size() < n; k++) @(posedge clock);
    tmo(k, 8 * STEP);
    repeat (SS + 8) @(posedge clock);
    for (int j = 0; j < n; j++) begin
      chk("on order", on_q[j], ord[4 * (n - 1 - j) +: 4]);
      if (j > 0)
        chk("on gap", on_t[j] - on_t[j - 1], STEP);
    end
    chk("soft start", ss_cyc, n * SS);
    if (!early)
      chk("stay on", off_q.size(), 0);
    grp_en <= 1'b0;
    if (late) begin
      for (k = 0; k < 50 && off_q.size() < 1; k++) @(posedge clock);
      tmo(k, 50);
      grp_en <= 1'b1;
    end
    for (k = 0; k < 9 * n * lm + 99 && dis_t == 0; k++) @(posedge clock);
    tmo(k, 9 * n * lm + 99);
    for (int j = 0; j < n; j++) begin
      chk("off order", off_q[j], on_q[n - 1 - j]);
      if (j > 0)
        chk("off wait", off_t[j] - off_t[j - 1] >= lm, 1);
    end
    chk("done wait", dis_t - off_t[n - 1] >= lm, 1);
    if (late) begin
      for (k = 0; k < 99 && on_q.size() <= n; k++) @(posedge clock);
      chk("restart", on_q.size() > n && on_t[n] > dis_t, 1);
    end
  endtask : run_seq

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {avs_read, avs_write, grp_en, avs_address, avs_writedata} = '0;
    {fail_count, total_checks, cyc, ss_cyc, dis_t} = '0;
    avs_byteenable = 4'hf;
    strap = 3'd1;
    lim = 8'd6;
    en_p = 5'h00;
    dis_p = 5'h00;
    sys_rst = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset_vals();
    t_regs();
    t_ticks();
    run_seq(3'd1, 4, 20'h01324, 1'b0, 1'b0, 8'd6);
    run_seq(3'd2, 4, 20'h01342, 1'b0, 1'b1, 8'd6);
    run_seq(3'd3, 4, 20'h01243, 1'b1, 1'b0, 8'd6);
    run_seq(3'd4, 5, 20'h14325, 1'b0, 1'b0, 8'd40);
    run_seq(3'd5, 4, 20'h01423, 1'b0, 1'b0, 8'd6);
    run_seq(3'd7, 4, 20'h01423, 1'b0, 1'b0, 8'd6);
    run_seq(3'd0, 3, 20'h00234, 1'b0, 1'b0, 8'd6);
    bus(4'h0, 1'b1, 32'h00000008);
    repeat (3) @(posedge clock);
    chk("ch1 by register", en[0], 1);
    conclude();
  end
endmodule : pmu_channel_sequencer_tb
